/* verilog/tws_pkg.sv */
/*
  Shared constants, types and states of the two-wire slave address match block.
  Assumes a 32-bit APB register bus and open-drain bus pins resolved outside.
*/
package tws_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] TWS_CTRL_IDX = 8'h00;
  localparam logic [7:0] TWS_STAT_IDX = 8'h01;
  localparam logic [7:0] TWS_OSA_IDX = 8'h02;
  localparam logic [7:0] TWS_IRQ_STAT_IDX = 8'h03;
  localparam logic [7:0] TWS_IRQ_CLR_IDX = 8'h04;
  localparam logic [7:0] TWS_IRQ_EN_IDX = 8'h05;
  localparam logic [7:0] TWS_CTRL_ADDR = 8'(TWS_CTRL_IDX << 2);
  localparam logic [7:0] TWS_STAT_ADDR = 8'(TWS_STAT_IDX << 2);
  localparam logic [7:0] TWS_OSA_ADDR = 8'(TWS_OSA_IDX << 2);
  localparam logic [7:0] TWS_IRQ_STAT_ADDR = 8'(TWS_IRQ_STAT_IDX << 2);
  localparam logic [7:0] TWS_IRQ_CLR_ADDR = 8'(TWS_IRQ_CLR_IDX << 2);
  localparam logic [7:0] TWS_IRQ_EN_ADDR = 8'(TWS_IRQ_EN_IDX << 2);

  // Own slave address register layout and reset value
  localparam logic [7:0] TWS_OSA_RESET = 8'hfe;
  localparam int unsigned TWS_SA_MSB = 7;
  localparam int unsigned TWS_SA_LSB = 1;
  localparam int unsigned TWS_GCE_BIT = 0;
  localparam logic [6:0] TWS_GENERAL_CALL_ADDR = 7'h00;

  // Control register layout
  localparam int unsigned TWS_CTRL_ACK_BIT = 0;
  localparam int unsigned TWS_CTRL_MASTER_BIT = 1;
  localparam logic [1:0] TWS_CTRL_RESET = 2'h0;

  // Event bits: bit 0 is the job done flag
  localparam int unsigned TWS_IRQ_W = 2;
  localparam int unsigned TWS_EV_DONE_BIT = 0;
  localparam int unsigned TWS_EV_GC_BIT = 1;

  localparam int unsigned TWS_BITS_PER_BYTE = 8;

  typedef struct packed {
    logic scl;
    logic sda;
  } tws_pins_s;

  typedef struct packed {
    logic start;
    logic stop;
    logic scl_fall;
    logic byte_done;
    logic [7:0] shift;
  } tws_rx_ev_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_SETUP,
    ST_ACK_DRIVE,
    ST_HELD,
    ST_IGNORE
  } tws_state_e;

endpackage

/* verilog/tws_bus_watch.sv */
/*
  Bus watcher: synchronises the two-wire pins, finds START, STOP and clock
  edges, and shifts in the first byte after each START.
  Assumes pins from outside the pclk domain; bus clock far slower than pclk.
*/
`timescale 1ns/1ps
module tws_bus_watch (
  input wire logic pclk,
  input wire logic presetn,
  input wire tws_pkg::tws_pins_s pins_in,
  output tws_pkg::tws_rx_ev_s ev
);
  import tws_pkg::*;

  tws_pins_s meta_ff;
  tws_pins_s sync_ff;
  tws_pins_s prev_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic done_ff;
  logic scl_rise;

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '{scl: 1'b1, sda: 1'b1};
      sync_ff <= '{scl: 1'b1, sda: 1'b1};
      prev_ff <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      meta_ff <= pins_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign scl_rise = sync_ff.scl && !prev_ff.scl;
  assign ev.start = sync_ff.scl && prev_ff.scl && prev_ff.sda && !sync_ff.sda;
  assign ev.stop = sync_ff.scl && prev_ff.scl && !prev_ff.sda && sync_ff.sda;
  assign ev.scl_fall = !sync_ff.scl && prev_ff.scl;
  assign ev.byte_done = done_ff;
  assign ev.shift = shift_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Only the byte right after START is collected; the count then parks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_ff <= 4'hf;
      shift_ff <= 8'h00;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (ev.start) begin
        bit_cnt_ff <= 4'h0;
      end else if (scl_rise && bit_cnt_ff < 4'(TWS_BITS_PER_BYTE)) begin
        shift_ff <= {shift_ff[6:0], sync_ff.sda};
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
        done_ff <= (bit_cnt_ff == 4'(TWS_BITS_PER_BYTE - 1));
      end
    end
  end

endmodule

/* verilog/tws_addr_match.sv */
/*
  Two-wire slave address match: APB registers, address comparator,
  acknowledge drive, clock stretching and interrupt.
  Assumes open-drain pins resolved outside from the output enables.
*/
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module tws_addr_match (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tws_pkg::tws_pins_s pins_in,
  output tws_pkg::tws_pins_s pins_out,
  output tws_pkg::tws_pins_s pins_oe,
  output logic irq
);
  import tws_pkg::*;

  tws_rx_ev_s ev;
  tws_state_e state_ff;
  tws_state_e nxt_state;
  logic [7:0] osa_ff;
  logic [1:0] ctrl_ff;
  logic [TWS_IRQ_W-1:0] irq_stat_ff;
  logic [TWS_IRQ_W-1:0] irq_en_ff;
  logic [7:0] last_addr_ff;
  logic [31:0] prdata_ff;
  logic sda_oe_ff;
  logic own_hit;
  logic gc_hit;
  logic respond;
  logic wr_en;
  logic mapped;
  logic [TWS_IRQ_W-1:0] ev_set;
  logic [TWS_IRQ_W-1:0] ev_clr;

  tws_bus_watch u_watch (
    .pclk(pclk),
    .presetn(presetn),
    .pins_in(pins_in),
    .ev(ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  // No wait states: every readable value is already a flop
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign prdata = prdata_ff;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    case (paddr)
      TWS_CTRL_ADDR, TWS_STAT_ADDR, TWS_OSA_ADDR, TWS_IRQ_STAT_ADDR, TWS_IRQ_CLR_ADDR,
      TWS_IRQ_EN_ADDR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osa_ff <= TWS_OSA_RESET;
    end else if (wr_en && paddr == TWS_OSA_ADDR) begin
      // Upper bits of the bus word are dropped; they read back as zero
      osa_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= TWS_CTRL_RESET;
    end else if (wr_en && paddr == TWS_CTRL_ADDR) begin
      ctrl_ff <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_ff <= '0;
    end else if (wr_en && paddr == TWS_IRQ_EN_ADDR) begin
      irq_en_ff <= pwdata[TWS_IRQ_W-1:0];
    end
  end

  // Reads are registered; data stands from the access edge onward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        TWS_CTRL_ADDR: prdata_ff <= {30'h0, ctrl_ff};
        TWS_STAT_ADDR: prdata_ff <= {16'h0, last_addr_ff, 5'h0, 3'(state_ff)};
        TWS_OSA_ADDR: prdata_ff <= {24'h0, osa_ff};
        TWS_IRQ_STAT_ADDR: prdata_ff <= {30'h0, irq_stat_ff};
        TWS_IRQ_EN_ADDR: prdata_ff <= {30'h0, irq_en_ff};
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address comparator
  assign own_hit = ev.shift[7:1] == osa_ff[TWS_SA_MSB:TWS_SA_LSB];
  assign gc_hit = ev.shift[7:1] == TWS_GENERAL_CALL_ADDR && osa_ff[TWS_GCE_BIT];
  // Master mode and a cleared acknowledge enable both make the device deaf
  assign respond = !ctrl_ff[TWS_CTRL_MASTER_BIT] && ctrl_ff[TWS_CTRL_ACK_BIT]
                   && (own_hit || gc_hit);

  // Whole byte kept, direction bit included, so software sees read or write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_addr_ff <= 8'h00;
    end else if (ev.byte_done) begin
      last_addr_ff <= ev.shift;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Addressing sequence
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (ev.start) begin
          nxt_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (ev.stop) begin
          nxt_state = ST_IDLE;
        end else if (ev.byte_done) begin
          nxt_state = respond ? ST_ACK_SETUP : ST_IGNORE;
        end
      end
      ST_ACK_SETUP: begin
        if (ev.scl_fall) begin
          nxt_state = ST_ACK_DRIVE;
        end
      end
      ST_ACK_DRIVE: begin
        if (ev.scl_fall) begin
          nxt_state = ST_HELD;
        end
      end
      ST_HELD: begin
        // Data phase lies outside this block: release and wait for a new START
        if (!irq_stat_ff[TWS_EV_DONE_BIT]) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IGNORE: begin
        if (ev.stop) begin
          nxt_state = ST_IDLE;
        end else if (ev.start) begin
          nxt_state = ST_ADDR;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    // A repeated START restarts addressing unless the clock is held
    // While held the bus is frozen for software, so a START there is not acted on
    if (ev.start && state_ff != ST_HELD) begin
      nxt_state = ST_ADDR;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Acknowledge is low on data for the whole ninth clock
  // Taken from the next state to win back one of the cycles lost in the synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_oe_ff <= 1'b0;
    end else begin
      sda_oe_ff <= nxt_state == ST_ACK_DRIVE;
    end
  end

  // Open drain: the pins are only ever pulled low, pull-ups make the high level
  assign pins_out = '{scl: 1'b0, sda: 1'b0};
  assign pins_oe.sda = sda_oe_ff;
  assign pins_oe.scl = state_ff == ST_HELD && irq_stat_ff[TWS_EV_DONE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Events and interrupt; a set in the clearing cycle wins
  assign ev_set[TWS_EV_DONE_BIT] = state_ff == ST_ACK_DRIVE && ev.scl_fall;
  assign ev_set[TWS_EV_GC_BIT] = state_ff == ST_ADDR && ev.byte_done && respond
                                 && gc_hit && !own_hit;
  // Writing zero to a bit leaves it alone, so one cause can be cleared at a time
  assign ev_clr = (wr_en && paddr == TWS_IRQ_CLR_ADDR) ? pwdata[TWS_IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= ev_set | (irq_stat_ff & ~ev_clr);
    end
  end

  // A level, not a pulse: it stands until the cause is cleared or masked
  assign irq = |(irq_stat_ff & irq_en_ff);

endmodule

/* testbench/tws_props.sv */
/*
  Checker for the address match block: stretch, ack and irq timing.
  Assumes the bind below and zero wait APB.
*/
`timescale 1ns/1ps
module tws_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire tws_pkg::tws_pins_s pins_in,
  input wire tws_pkg::tws_pins_s pins_oe,
  input wire logic irq
);
  import tws_pkg::*;
  logic acc;
  logic clr;
  assign acc = psel && penable && pwrite;
  assign clr = acc && paddr == TWS_IRQ_CLR_ADDR && pwdata[0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_sda_edge; $changed(pins_oe.sda) |-> !pins_in.scl; endproperty
  a_sda_edge: assert property (p_sda_edge) else $error("ack moved with scl high");
  property p_ack_len; $rose(pins_oe.sda) |=> pins_oe.sda [*8]; endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack too short");
  property p_gate; $rose(pins_oe.scl) |-> $fell(pins_oe.sda); endproperty
  a_gate: assert property (p_gate) else $error("stretch not at ack end");
  property p_hold; pins_oe.scl && !clr |=> pins_oe.scl; endproperty
  a_hold: assert property (p_hold) else $error("stretch dropped");
  property p_free; pins_oe.scl && clr |=> !pins_oe.scl; endproperty
  a_free: assert property (p_free) else $error("stretch kept");
  property p_irq;
    // A general call hit with no own address hit raises its bit at the end of the address byte, scl still high
    $rose(irq) |-> $rose(pins_oe.scl) || $past(acc && paddr == TWS_IRQ_EN_ADDR)
      || (pins_in.scl && !pins_oe.sda && !pins_oe.scl);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  property p_held; $rose(pins_oe.sda) |-> !pins_oe.scl; endproperty
  a_held: assert property (p_held) else $error("ack while held");
  property p_err; psel && penable && paddr >= 8'h18 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no error on hole");
endmodule

bind tws_addr_match tws_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pslverr(pslverr), .pins_in(pins_in), .pins_oe(pins_oe), .irq(irq));

/* testbench/tws_master_model.sv */
/*
  Two-wire bus master model.
  Assumes pull-ups on both lines; bit clock 250 ns (25 pclk cycles) when not stretched.
*/
`timescale 1ns/1ps
module tws_master_model (
  input wire logic pclk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_oe,
  output logic sda_oe
);
  initial begin
    scl_oe = 1'h0;
    sda_oe = 1'h0;
  end
  task automatic half();
    repeat (8) @(posedge pclk);
  endtask
  // Waits out a slave that stretches the clock low
  task automatic rise();
    scl_oe <= 1'h0;
    @(posedge pclk);
    while (!scl_in) @(posedge pclk);
    half();
  endtask
  task automatic start();
    sda_oe <= 1'h0;
    half();
    rise();
    sda_oe <= 1'h1;
    half();
    scl_oe <= 1'h1;
    half();
  endtask
  task automatic xfer(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      sda_oe <= (i > 0) ? !b[i-1] : 1'h0;
      half();
      rise();
      ack = !sda_in;
      scl_oe <= 1'h1;
      half();
    end
  endtask
  task automatic stop();
    sda_oe <= 1'h1;
    half();
    rise();
    sda_oe <= 1'h0;
    half();
  endtask
endmodule

/* testbench/tb_top.sv */
/*
  Self-checking bench for the address match block.
  Assumes the master model on the bus side.
*/
`timescale 1ns/1ps
module tb_top;
  import tws_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, m_scl, m_sda, ack, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  tws_pins_s pins_in, pins_out, pins_oe;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // Open-drain lines with pull-ups
  assign pins_in = {!(m_scl || pins_oe.scl), !(m_sda || pins_oe.sda)};
  tws_addr_match uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins_in(pins_in), .pins_out(pins_out), .pins_oe(pins_oe), .irq(irq));
  tws_master_model m (.pclk(pclk), .scl_in(pins_in.scl), .sda_in(pins_in.sda),
    .scl_oe(m_scl), .sda_oe(m_sda));
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // One addressing on the bus, then the flag is read and cleared
  task automatic go(input logic [1:0] c, input logic [7:0] osa, input logic [7:0] b,
                    input logic a, input logic [1:0] st, input logic [1:0] en);
    apb(1'h1, TWS_CTRL_ADDR, 32'(c));
    apb(1'h1, TWS_OSA_ADDR, 32'(osa));
    apb(1'h1, TWS_IRQ_EN_ADDR, 32'(en));
    m.start();
    m.xfer(b, ack);
    chk(ack, a);
    chk(irq, |(st & en));
    apb(1'h0, TWS_IRQ_STAT_ADDR, 32'h0);
    chk(rd, st);
    chk(pins_oe.scl, a);
    apb(1'h0, TWS_STAT_ADDR, 32'h0);
    chk(rd[15:8], b);
    chk(rd[2:0], a ? 3'(ST_HELD) : 3'(ST_IGNORE));
    apb(1'h1, TWS_IRQ_CLR_ADDR, 32'(st));
    apb(1'h0, TWS_IRQ_STAT_ADDR, 32'h0);
    chk(rd, 32'h0);
    chk(pins_oe.scl, 1'h0);
    m.stop();
  endtask
  task automatic t_regs();
    apb(1'h0, TWS_OSA_ADDR, 32'h0);
    chk(rd, 32'(TWS_OSA_RESET));
    apb(1'h1, TWS_OSA_ADDR, 32'h1234_56a5);
    apb(1'h0, TWS_OSA_ADDR, 32'h0);
    chk(rd, 32'ha5);
    apb(1'h0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'h1);
    chk(pready, 1'h1);
    chk(pins_out, 2'h0);
  endtask
  task automatic t_own();
    go(2'h1, 8'h54, 8'h55, 1'h1, 2'h1, 2'h3);
    go(2'h1, 8'h55, 8'h54, 1'h1, 2'h1, 2'h2);
    go(2'h1, 8'hfe, 8'hff, 1'h1, 2'h1, 2'h3);
  endtask
  task automatic t_refuse();
    go(2'h1, 8'h54, 8'h56, 1'h0, 2'h0, 2'h3);
    go(2'h0, 8'h54, 8'h54, 1'h0, 2'h0, 2'h3);
    go(2'h3, 8'h54, 8'h54, 1'h0, 2'h0, 2'h3);
    go(2'h1, 8'h54, 8'h00, 1'h0, 2'h0, 2'h3);
  endtask
  task automatic t_gcall();
    go(2'h1, 8'h55, 8'h00, 1'h1, 2'h3, 2'h3);
    go(2'h1, 8'h01, 8'h00, 1'h1, 2'h1, 2'h3);
  endtask
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_own();
    t_refuse();
    t_gcall();
    close_out();
  end
  // A hang costs a mismatch, then the normal report
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
endmodule
